/* File: hw/ssio_top.sv */
// Slave status word, scan counters and cyclic data area behind an Avalon-MM slave.
`timescale 1ns/1ps
`include "ssio_defines.svh"
//Function
// - warning flag while any error cause present
// - command-ready high when idle, low while busy
// - sync-busy high during synchronisation only
// - sync-ready on conditions, cleared by resume-disable
// - synced flag high in synchronous state
// - receive error increments both error counters
// - at most 6 or 13 data words
// - exchange works without scan counter updates
// - master scan counter shown to slave
// - local status equals status sent to master
// - resume-disable zero resumes synchronisation automatically
module ssio_top
	import ssio_pkg::*;
(
	input wire logic clk, // 25 MHz clock
	input wire logic rst_b, // synchronous reset, active low
	input wire logic [7:0] avs_address, // word address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // byte lanes
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall
	input wire logic link_frame_valid, // one-cycle pulse: frame received
	input wire logic link_frame32, // frame is 32-byte format
	input wire logic [7:0] link_rx_scan, // master scan counter byte
	input wire logic [3:0] link_rx_idx, // data word index in frame
	input wire logic link_rx_we, // data word write pulse
	input wire logic [15:0] link_rx_data, // received data word
	input wire logic [3:0] link_tx_idx, // data word index to send
	input wire logic err_rx, // receive error pulse
	input wire logic err_unsup_cmd, // unsupported command level
	input wire logic err_cycle, // cycle out of range level
	input wire logic err_cmd_data, // bad command data level
	input wire logic err_exec_cond, // execution condition unmet level
	input wire logic cmd_busy, // command processing under way
	input wire logic sync_cond_ok, // synchronisation conditions met
	output logic [15:0] link_tx_status, // status word sent to master
	output logic [7:0] link_tx_scan, // slave scan counter byte sent
	output logic [15:0] link_tx_data, // data word sent at link_tx_idx
	output logic irq // level interrupt
);
	// ==========================================================
	// Input synchronisers; error and condition levels come from link logic
	logic [4:0] err_s1_q, err_s2_q;
	logic cond_s1_q, cond_s2_q, busy_s1_q, busy_s2_q;
	// The busy pair resets to busy so command-ready cannot claim readiness
	// before the synchronisers have seen the real level.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			err_s1_q <= 5'h00;
			err_s2_q <= 5'h00;
			cond_s1_q <= 1'b0;
			cond_s2_q <= 1'b0;
			busy_s1_q <= 1'b1;
			busy_s2_q <= 1'b1;
		end else begin
			err_s1_q <= {err_exec_cond, err_cmd_data, err_cycle, err_unsup_cmd, err_rx};
			err_s2_q <= err_s1_q;
			cond_s1_q <= sync_cond_ok;
			cond_s2_q <= cond_s1_q;
			busy_s1_q <= cmd_busy;
			busy_s2_q <= busy_s1_q;
		end
	end

	// ==========================================================
	// Registers
	// Word map: 0 master scan byte, 1 status, 2 control (bit 0 resume-disable),
	// 3 slave scan byte, 4 and 5 error counters (any write clears unless a receive error counts in that cycle), 6 interrupt
	// status (write one to clear), 7 interrupt mask, 8 frame format and word count,
	// 0x10 upward input words, 0x20 upward output words.
	// Words past the current frame size read zero and are never sent.
	logic [15:0] ctrl_q, ctrl_d, mask_q, mask_d, irqst_q, irqst_d;
	logic [7:0] out_scan_q, out_scan_d, in_scan_q, in_scan_d;
	logic [15:0] data_in_q [`SSIO_MAX_WORDS];
	logic [15:0] data_out_q [`SSIO_MAX_WORDS];
	logic [15:0] data_in_d [`SSIO_MAX_WORDS];
	logic [15:0] data_out_d [`SSIO_MAX_WORDS];
	logic frame32_q, frame32_d, rx_prev_q, rx_prev_d, warn_prev_q, warn_prev_d;
	logic sync_prev_q, sync_prev_d;
	logic [15:0] status_q, status_d;
	logic [31:0] rdata_q, rdata_d;
	logic wait_q, wait_d, irq_q, irq_d;
	logic [15:0] tx_data_q, tx_data_d;
	logic [15:0] io_err_cnt, in_err_cnt;
	logic sync_busy, sync_ready, synced, rx_pulse, warn, wr_acc, rd_acc;
	logic [15:0] wmask;

	function automatic logic [3:0] frame_words(input logic f32);
		frame_words = f32 ? `SSIO_WORDS_32 : `SSIO_WORDS_17;
	endfunction

	function automatic logic idx_ok(input logic [3:0] idx, input logic f32);
		idx_ok = idx < frame_words(f32);
	endfunction

	function automatic logic area_hit(input logic [7:0] a, input logic [3:0] page, input logic f32);
		area_hit = (a[7:4] == page) && idx_ok(a[3:0], f32);
	endfunction

	ssio_sync_fsm u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.cond_ok(cond_s2_q),
		.resume_dis(ctrl_q[`SSIO_CTL_RESUME_DIS]),
		.busy(sync_busy),
		.ready(sync_ready),
		.synced(synced)
	);

	assign rx_pulse = err_s2_q[0] && !rx_prev_q;
	assign warn = |err_s2_q;
	// Writes land on the edge at which the master sees waitrequest low, never earlier.
	assign wr_acc = avs_write && !wait_q;
	// Reads are captured one edge earlier so that the data stand when waitrequest is low.
	assign rd_acc = avs_read && wait_q;
	assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	// Both counters see the same edge-detected pulse, so they cannot drift apart
	// until software clears one of them.
	ssio_err_cnt u_io_err (
		.clk(clk),
		.rst_b(rst_b),
		.inc(rx_pulse),
		.clr(wr_acc && avs_address == 8'(`SSIO_IDX_IO_ERR)),
		.count(io_err_cnt)
	);

	ssio_err_cnt u_in_err (
		.clk(clk),
		.rst_b(rst_b),
		.inc(rx_pulse),
		.clr(wr_acc && avs_address == 8'(`SSIO_IDX_IN_ERR)),
		.count(in_err_cnt)
	);

	// ==========================================================
	// Next-state logic
	always_comb begin
		ctrl_d = ctrl_q;
		mask_d = mask_q;
		out_scan_d = out_scan_q;
		in_scan_d = in_scan_q;
		frame32_d = frame32_q;
		rx_prev_d = err_s2_q[0];
		warn_prev_d = warn;
		sync_prev_d = synced;
		// Status bits 0, 3, 4 and the upper byte stay zero.
		status_d = 16'h0000;
		status_d[`SSIO_ST_WARN] = warn;
		status_d[`SSIO_ST_COMMAND_READY_FLAG] = !busy_s2_q;
		status_d[`SSIO_ST_SYNC_BUSY_FLAG] = sync_busy;
		status_d[`SSIO_ST_SYNC_READY_FLAG] = sync_ready;
		status_d[`SSIO_ST_SYNC] = synced;
		wait_d = 1'b1;
		if (link_frame_valid) begin
			// The scan byte is stored as received; a stale value is harmless.
			in_scan_d = link_rx_scan;
			frame32_d = link_frame32;
		end
		if (wr_acc) begin
			case (avs_address)
				8'(`SSIO_IDX_CTRL): ctrl_d = (ctrl_q & ~wmask) | (avs_writedata[15:0] & wmask);
				8'(`SSIO_IDX_OUT_SCAN): begin
					if (avs_byteenable[0]) begin
						out_scan_d = avs_writedata[7:0];
					end
				end
				8'(`SSIO_IDX_IRQ_MASK): mask_d = (mask_q & ~wmask) | (avs_writedata[15:0] & wmask);
				default: ;
			endcase
		end
		// One wait cycle per access; waitrequest drops for exactly one cycle.
		if ((avs_read || avs_write) && wait_q) begin
			wait_d = 1'b0;
		end
		// An index past the frame sends zero so that stale words never leak out.
		tx_data_d = idx_ok(link_tx_idx, frame32_q) ? data_out_q[link_tx_idx] : 16'h0000;
	end

	// ==========================================================
	// Interrupt status
	// Events are applied after the clear so a coincident event survives.
	always_comb begin
		irqst_d = irqst_q;
		if (wr_acc && avs_address == 8'(`SSIO_IDX_IRQ_STAT)) begin
			irqst_d = irqst_q & ~(avs_writedata[15:0] & wmask);
		end
		if (rx_pulse) irqst_d[`SSIO_IRQ_RX_ERR] = 1'b1;
		if (warn && !warn_prev_q) irqst_d[`SSIO_IRQ_WARN] = 1'b1;
		if (synced != sync_prev_q) irqst_d[`SSIO_IRQ_SYNC] = 1'b1;
		if (link_frame_valid && link_rx_scan != in_scan_q) irqst_d[`SSIO_IRQ_FRESH] = 1'b1;
		// The next status is masked so that a new event raises irq one cycle sooner.
		irq_d = |(irqst_d & mask_q);
	end

	// ==========================================================
	// Read data
	// Reads have no side effects, so capturing them in the wait cycle is safe.
	always_comb begin
		rdata_d = rdata_q;
		if (rd_acc) begin
			rdata_d = 32'h0000_0000;
			case (avs_address)
				8'(`SSIO_IDX_SCAN): rdata_d[7:0] = in_scan_q;
				8'(`SSIO_IDX_STATUS): rdata_d[15:0] = status_q;
				8'(`SSIO_IDX_CTRL): rdata_d[15:0] = ctrl_q;
				8'(`SSIO_IDX_OUT_SCAN): rdata_d[7:0] = out_scan_q;
				8'(`SSIO_IDX_IO_ERR): rdata_d[15:0] = io_err_cnt;
				8'(`SSIO_IDX_IN_ERR): rdata_d[15:0] = in_err_cnt;
				8'(`SSIO_IDX_IRQ_STAT): rdata_d[15:0] = irqst_q;
				8'(`SSIO_IDX_IRQ_MASK): rdata_d[15:0] = mask_q;
				8'(`SSIO_IDX_FRAME): rdata_d[4:0] = {frame32_q, frame_words(frame32_q)};
				default: begin
					if (area_hit(avs_address, 4'(`SSIO_IDX_DATA_IN >> 4), frame32_q)) begin
						rdata_d[15:0] = data_in_q[avs_address[3:0]];
					end else if (area_hit(avs_address, 4'(`SSIO_IDX_DATA_OUT >> 4), frame32_q)) begin
						rdata_d[15:0] = data_out_q[avs_address[3:0]];
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Cyclic data words
	// Input words are accepted against the format of the frame being received, so a
	// short frame cannot overwrite the words that only a long frame carries.
	for (genvar i = 0; i < `SSIO_MAX_WORDS; i++) begin : g_words
		always_comb begin
			data_in_d[i] = data_in_q[i];
			data_out_d[i] = data_out_q[i];
			if (link_rx_we && link_rx_idx == 4'(i) && idx_ok(4'(i), link_frame32)) begin
				data_in_d[i] = link_rx_data;
			end
			if (wr_acc && avs_address == 8'(`SSIO_IDX_DATA_OUT + i)) begin
				data_out_d[i] = (data_out_q[i] & ~wmask) | (avs_writedata[15:0] & wmask);
			end
		end

		always_ff @(posedge clk) begin
			if (!rst_b) begin
				data_in_q[i] <= 16'h0000;
				data_out_q[i] <= 16'h0000;
			end else begin
				data_in_q[i] <= data_in_d[i];
				data_out_q[i] <= data_out_d[i];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ctrl_q <= `SSIO_RST_CTRL;
			mask_q <= `SSIO_RST_MASK;
			irqst_q <= 16'h0000;
			out_scan_q <= 8'h00;
			in_scan_q <= 8'h00;
			frame32_q <= 1'b0;
			rx_prev_q <= 1'b0;
			warn_prev_q <= 1'b0;
			sync_prev_q <= 1'b0;
			status_q <= 16'h0000;
			rdata_q <= 32'h0000_0000;
			wait_q <= 1'b1;
			irq_q <= 1'b0;
			tx_data_q <= 16'h0000;
		end else begin
			ctrl_q <= ctrl_d;
			mask_q <= mask_d;
			irqst_q <= irqst_d;
			out_scan_q <= out_scan_d;
			in_scan_q <= in_scan_d;
			frame32_q <= frame32_d;
			rx_prev_q <= rx_prev_d;
			warn_prev_q <= warn_prev_d;
			sync_prev_q <= sync_prev_d;
			status_q <= status_d;
			rdata_q <= rdata_d;
			wait_q <= wait_d;
			irq_q <= irq_d;
			tx_data_q <= tx_data_d;
		end
	end

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign link_tx_status = status_q;
	assign link_tx_scan = out_scan_q;
	assign link_tx_data = tx_data_q;
	assign irq = irq_q;
endmodule

/* File: hw/ssio_defines.svh */
// Offsets, field positions, reset values and timing counts of the slave status and cyclic I/O block.
`ifndef SSIO_DEFINES_SVH
`define SSIO_DEFINES_SVH

// ==========================================================
// Register word offsets (byte address = index * 4)
`define SSIO_IDX_SCAN 4'h0
`define SSIO_IDX_STATUS 4'h1
`define SSIO_IDX_CTRL 4'h2
`define SSIO_IDX_OUT_SCAN 4'h3
`define SSIO_IDX_IO_ERR 4'h4
`define SSIO_IDX_IN_ERR 4'h5
`define SSIO_IDX_IRQ_STAT 4'h6
`define SSIO_IDX_IRQ_MASK 4'h7
`define SSIO_IDX_FRAME 4'h8
`define SSIO_IDX_DATA_IN 6'h10
`define SSIO_IDX_DATA_OUT 6'h20

// ==========================================================
// Status word bit positions
`define SSIO_ST_WARN 1
`define SSIO_ST_COMMAND_READY_FLAG 2
`define SSIO_ST_SYNC_BUSY_FLAG 5
`define SSIO_ST_SYNC_READY_FLAG 6
`define SSIO_ST_SYNC 7

// Control word bit positions.
`define SSIO_CTL_RESUME_DIS 0

// Interrupt status bit positions.
`define SSIO_IRQ_RX_ERR 0
`define SSIO_IRQ_WARN 1
`define SSIO_IRQ_SYNC 2
`define SSIO_IRQ_FRESH 3

// ==========================================================
// Frame sizes and reset values
`define SSIO_WORDS_17 4'd6
`define SSIO_WORDS_32 4'd13
`define SSIO_MAX_WORDS 13
`define SSIO_RST_CTRL 16'h0000
`define SSIO_RST_MASK 16'h0000

// ==========================================================
// Timing: clock period and synchronisation settling time
`define SSIO_CLK_NS 40
`define SSIO_SYNC_SETTLE_NS 400
`define SSIO_SYNC_SETTLE_CYC ((`SSIO_SYNC_SETTLE_NS + `SSIO_CLK_NS - 1) / `SSIO_CLK_NS)

`endif

/* File: hw/ssio_pkg.sv */
// Types shared by the slave status and cyclic I/O block.
package ssio_pkg;
	typedef enum logic [1:0] {
		SSIO_ASYNC,
		SSIO_SYNCING,
		SSIO_SYNCED
	} ssio_sync_t;
endpackage

/* File: hw/ssio_sync_fsm.sv */
// Slave synchronisation state machine.
`timescale 1ns/1ps
`include "ssio_defines.svh"
module ssio_sync_fsm
	import ssio_pkg::*;
(
	input wire logic clk, // clock
	input wire logic rst_b, // synchronous reset, active low
	input wire logic cond_ok, // all synchronisation conditions met
	input wire logic resume_dis, // resume-disable control bit
	output logic busy, // synchronisation under way
	output logic ready, // preparation complete
	output logic synced // synchronous state
);
	ssio_sync_t state_q, state_d;
	logic [7:0] cnt_q, cnt_d;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		case (state_q)
			SSIO_ASYNC: begin
				cnt_d = 8'h00;
				if (cond_ok && !resume_dis) begin
					state_d = SSIO_SYNCING;
				end
			end
			SSIO_SYNCING: begin
				if (!cond_ok || resume_dis) begin
					state_d = SSIO_ASYNC;
				end else if (cnt_q == 8'(`SSIO_SYNC_SETTLE_CYC - 1)) begin
					state_d = SSIO_SYNCED;
				end else begin
					cnt_d = cnt_q + 8'h01;
				end
			end
			SSIO_SYNCED: begin
				if (!cond_ok) begin
					state_d = SSIO_ASYNC;
				end
			end
			default: state_d = SSIO_ASYNC;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_q <= SSIO_ASYNC;
			cnt_q <= 8'h00;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	assign busy = (state_q == SSIO_SYNCING);
	assign ready = cond_ok && !resume_dis;
	assign synced = (state_q == SSIO_SYNCED);
endmodule

/* File: hw/ssio_err_cnt.sv */
// Saturating 16-bit event counter for the system error counters.
`timescale 1ns/1ps
module ssio_err_cnt (
	input wire logic clk, // clock
	input wire logic rst_b, // synchronous reset, active low
	input wire logic inc, // count one event
	input wire logic clr, // clear the count
	output logic [15:0] count // current count
);
	logic [15:0] cnt_q, cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (inc && cnt_q != 16'hffff) begin
			cnt_d = cnt_q + 16'h0001;
		end else if (clr) begin
			cnt_d = 16'h0000;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cnt_q <= 16'h0000;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign count = cnt_q;
endmodule

/* File: verification/ssio_chk.sv */
// Port assertions of the slave status and cyclic I/O block.
`timescale 1ns/1ps
module ssio_chk (
	input wire logic clk, // clock
	input wire logic rst_b, // synchronous reset, active low
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic avs_waitrequest, // stall
	input wire logic err_rx, // receive error
	input wire logic err_unsup_cmd, // unsupported command
	input wire logic err_cycle, // cycle out of range
	input wire logic err_cmd_data, // bad command data
	input wire logic err_exec_cond, // execution condition unmet
	input wire logic cmd_busy, // command processing
	input wire logic sync_cond_ok, // synchronisation conditions met
	input wire logic [3:0] link_tx_idx, // output word index
	input wire logic [15:0] link_tx_status, // status sent to master
	input wire logic [15:0] link_tx_data // output word sent
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	// ==========================================================
	// Properties
	// The repetition counts leave room for the input synchronisers and the output register.
	property p_wait;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	property p_unused;
		link_tx_status[15:8] == 8'h00 && link_tx_status[4:3] == 2'h0 && !link_tx_status[0];
	endproperty
	property p_busy;
		cmd_busy [*6] |=> !link_tx_status[2];
	endproperty
	property p_idle;
		!cmd_busy [*6] |=> link_tx_status[2];
	endproperty
	property p_warn;
		err_cycle [*6] |=> link_tx_status[1];
	endproperty
	property p_nowarn;
		!(err_rx || err_unsup_cmd || err_cycle || err_cmd_data || err_exec_cond) [*8]
			|=> !link_tx_status[1];
	endproperty
	property p_excl;
		!(link_tx_status[5] && link_tx_status[7]);
	endproperty
	property p_lost;
		!sync_cond_ok [*7] |=> link_tx_status[7:5] == 3'h0;
	endproperty
	property p_order;
		$rose(link_tx_status[7]) |-> $past(link_tx_status[5]);
	endproperty
	property p_range;
		link_tx_idx >= 4'hd |=> link_tx_data == 16'h0000;
	endproperty
	// ==========================================================
	// Assertions and covers
	a_wait: assert property (p_wait) else $error("no answer one cycle after request");
	a_unused: assert property (p_unused) else $error("unused status bit set");
	a_busy: assert property (p_busy) else $error("command ready while busy");
	a_idle: assert property (p_idle) else $error("command ready missing");
	a_warn: assert property (p_warn) else $error("warning missing");
	a_nowarn: assert property (p_nowarn) else $error("warning stuck");
	a_excl: assert property (p_excl) else $error("busy while synced");
	a_lost: assert property (p_lost) else $error("sync flags without conditions");
	a_order: assert property (p_order) else $error("synced without busy phase");
	a_range: assert property (p_range) else $error("word beyond frame sent");
	c_sync: cover property ($rose(link_tx_status[7]));
	c_warn: cover property ($rose(link_tx_status[1]));
	c_read: cover property (avs_read && !avs_waitrequest);
endmodule
bind ssio_top ssio_chk u_chk (.*);

/* File: verification/ssio_link_model.sv */
// Behavioural link master that writes frames into the block.
`timescale 1ns/1ps
module ssio_link_model (
	input wire logic clk, // clock
	input wire logic send, // one-cycle frame request
	input wire logic f32, // 32-byte frame wanted
	input wire logic [7:0] scan, // master scan byte
	input wire logic [15:0] base, // data pattern seed
	output logic link_frame_valid, // frame end pulse
	output logic link_frame32, // frame format
	output logic [7:0] link_rx_scan, // scan byte
	output logic [3:0] link_rx_idx, // word index
	output logic link_rx_we, // word strobe
	output logic [15:0] link_rx_data, // word
	output logic [3:0] link_tx_idx // output word index
);
	initial begin
		link_frame_valid = 1'b0;
		link_frame32 = 1'b0;
		link_rx_scan = 8'h00;
		link_rx_idx = 4'h0;
		link_rx_we = 1'b0;
		link_rx_data = 16'h0000;
		link_tx_idx = 4'h0;
	end
	always @(posedge clk)
		link_tx_idx <= link_tx_idx + 4'h1;
	// Released data, format and scan lines show the inverse of their last value so stale data cannot pass; the word index holds.
	always @(posedge clk) begin
		if (send) begin
			// The format stands from the first word so the block sizes the frame as it arrives.
			link_frame32 <= f32;
			for (int k = 0; k < (f32 ? 13 : 6); k++) begin
				link_rx_we <= 1'b1;
				link_rx_idx <= 4'(k);
				link_rx_data <= base ^ 16'(k);
				@(posedge clk);
			end
			link_rx_we <= 1'b0;
			link_rx_data <= ~link_rx_data;
			link_frame_valid <= 1'b1;
			link_rx_scan <= scan;
			@(posedge clk);
			link_frame_valid <= 1'b0;
			link_frame32 <= ~link_frame32;
			link_rx_scan <= ~link_rx_scan;
		end
	end
endmodule

/* File: verification/testbench.sv */
// Self-checking testbench of the slave status and cyclic I/O block.
`timescale 1ns/1ps
module testbench;
	logic clk, rst_b, avs_read, avs_write, avs_waitrequest, irq, send, f32;
	logic link_frame_valid, link_frame32, link_rx_we, err_rx, err_unsup_cmd, err_cycle;
	logic err_cmd_data, err_exec_cond, cmd_busy, sync_cond_ok;
	logic [7:0] avs_address, link_rx_scan, link_tx_scan, scan;
	logic [31:0] avs_writedata, avs_readdata, rng;
	logic [3:0] avs_byteenable, link_rx_idx, link_tx_idx;
	logic [15:0] link_rx_data, link_tx_status, link_tx_data, base;
	logic [31:0] expq[$];
	int miscompares;
	int n_checks;
	ssio_top dut (.*);
	ssio_link_model u_link (.*);
	// ==========================================================
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("checks=%0d miscompares=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		expq.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic step(input logic [15:0] e);
		repeat (30) @(posedge clk);
		rd(8'h01, {16'h0000, e});
		cmp({16'h0000, link_tx_status}, {16'h0000, e});
	endtask
	task automatic frame(input logic b32, input logic [7:0] s);
		rng = xs(rng);
		base <= rng[15:0];
		f32 <= b32;
		scan <= s;
		send <= 1'b1;
		@(posedge clk);
		send <= 1'b0;
		repeat (20) @(posedge clk);
	endtask
	always @(posedge clk)
		if (avs_read && avs_waitrequest === 1'b0 && expq.size() > 0)
			cmp(avs_readdata, expq.pop_front());
	// ==========================================================
	// Stimulus
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		#(40 * 6000);
		miscompares++;
		conclude();
	end
	initial begin
		{rst_b, avs_read, avs_write, err_rx, cmd_busy, sync_cond_ok, send, f32} = 8'h00;
		{err_unsup_cmd, err_cycle, err_cmd_data, err_exec_cond} = 4'h0;
		{avs_address, scan, avs_writedata, base} = 64'h0;
		avs_byteenable = 4'hf;
		rng = 32'h00000e45;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd(8'h3f, 32'h0);
		bus(1'b1, 8'h01, 32'hffff);
		sync_cond_ok <= 1'b1;
		step(16'h00c4);
		bus(1'b1, 8'h02, 32'h1);
		step(16'h0084);
		sync_cond_ok <= 1'b0;
		step(16'h0004);
		sync_cond_ok <= 1'b1;
		step(16'h0004);
		bus(1'b1, 8'h02, 32'h0);
		step(16'h00c4);
		cmd_busy <= 1'b1;
		step(16'h00c0);
		cmd_busy <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			{err_unsup_cmd, err_cycle, err_cmd_data, err_exec_cond} <= 4'h1 << i;
			step(16'h00c6);
			{err_unsup_cmd, err_cycle, err_cmd_data, err_exec_cond} <= 4'h0;
			step(16'h00c4);
		end
		bus(1'b1, 8'h04, 32'h0);
		bus(1'b1, 8'h05, 32'h0);
		bus(1'b1, 8'h06, 32'hf);
		bus(1'b1, 8'h07, 32'h1);
		repeat (3) begin
			err_rx <= 1'b1;
			@(posedge clk);
			err_rx <= 1'b0;
			repeat (6) @(posedge clk);
		end
		repeat (6) @(posedge clk);
		rd(8'h04, 32'h3);
		rd(8'h05, 32'h3);
		cmp({31'h0, irq}, 32'h1);
		bus(1'b1, 8'h07, 32'h0);
		repeat (2) @(posedge clk);
		cmp({31'h0, irq}, 32'h0);
		bus(1'b1, 8'h07, 32'h1);
		bus(1'b1, 8'h06, 32'hf);
		repeat (2) @(posedge clk);
		cmp({31'h0, irq}, 32'h0);
		frame(1'b1, rng[7:0]);
		rd(8'h00, {24'h0, scan});
		rd(8'h06, 32'h8);
		rd(8'h08, 32'h1d);
		rd(8'h1c, {16'h0, base ^ 16'hc});
		frame(1'b0, scan);
		rd(8'h15, {16'h0, base ^ 16'h5});
		rd(8'h16, 32'h0);
		rd(8'h08, 32'h06);
		bus(1'b1, 8'h20, {16'h0, rng[31:16]});
		rd(8'h20, {16'h0, rng[31:16]});
		do @(posedge clk); while (link_tx_idx !== 4'h0);
		@(posedge clk);
		cmp({16'h0, link_tx_data}, {16'h0, rng[31:16]});
		avs_byteenable <= 4'h1;
		bus(1'b1, 8'h21, 32'hffff);
		avs_byteenable <= 4'hf;
		rd(8'h21, 32'h00ff);
		bus(1'b1, 8'h03, {24'h0, rng[7:0]});
		repeat (2) @(posedge clk);
		cmp({24'h0, link_tx_scan}, {24'h0, rng[7:0]});
		conclude();
	end
endmodule
